// ### rtl/scan_bridge_pkg.sv
// constants, states and carriers shared by the user scan bridge
package scan_bridge_pkg;

   // ==========================================================
   // instruction register
   localparam int IR_WIDTH = 8;
   localparam logic [7:0] USER_FIRST = 8'h10;
   localparam logic [7:0] USER_LAST = 8'h7F;
   localparam logic [7:0] OP_EXTEST = 8'h00;
   localparam logic [7:0] OP_SAMPLE = 8'h01;
   localparam logic [7:0] OP_BYPASS = 8'hFF;
   localparam logic [7:0] IR_CAPTURE = 8'h01;
   localparam logic [7:0] IR_RESET = OP_BYPASS;

   // ==========================================================
   // stream and timing
   localparam int WORD_BITS = 8;
   localparam int FIFO_DEPTH = 32;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] TMS_RESET_CYCLES = 3'h5;
   localparam int CLK_PERIOD_NS = 50;
   localparam int TCK_PERIOD_NS = 400;
   // each tck level must be seen by the two-stage sampler
   localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / 2 / CLK_PERIOD_NS;

   // ==========================================================
   // positions in the sampled pin vector
   localparam int SYN_TCK = 0;
   localparam int SYN_TMS = 1;
   localparam int SYN_TDI = 2;
   localparam int SYN_TRST = 3;
   localparam int SYN_USER_SERIAL_OUT = 4;
   localparam int SYN_WIDTH = 5;
   localparam logic [4:0] SYN_RESET = 5'h00;

   // ==========================================================
   // controller states
   typedef enum logic [3:0] {
      TEST_LOGIC_RESET = 4'h0,
      RUN_TEST_IDLE = 4'h1,
      SELECT_DR = 4'h2,
      CAPTURE_DR = 4'h3,
      SHIFT_DR = 4'h4,
      EXIT1_DR = 4'h5,
      PAUSE_DR = 4'h6,
      EXIT2_DR = 4'h7,
      UPDATE_DR = 4'h8,
      SELECT_IR = 4'h9,
      CAPTURE_IR = 4'hA,
      SHIFT_IR = 4'hB,
      EXIT1_IR = 4'hC,
      PAUSE_IR = 4'hD,
      EXIT2_IR = 4'hE,
      UPDATE_IR = 4'hF
   } tap_state_t;

   typedef struct packed {
      logic [7:0] instr;
      logic [7:0] data;
   } scan_word_t;

endpackage

// ### rtl/scan_fifo.sv
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scan_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // ==========================================================
   // elaboration check
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      begin : g_bad_size
         $error("scan_fifo: depth must be a power of two");
      end
   endgenerate

   // ==========================================================
   // flags and pointers
   assign in_ready = (count != FULL);
   assign out_valid = (count != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + AW'(1);
         if (pop)
            rd_ptr <= rd_ptr + AW'(1);
         if (push && !pop)
            count <= count + (AW+1)'(1);
         else if (pop && !push)
            count <= count - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

endmodule
`default_nettype wire

// ### rtl/tap_state_machine.sv
// sixteen-state test access port controller
`timescale 1ns/1ps
`default_nettype none
module tap_state_machine (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic trst_n,
   input wire logic step,
   input wire logic tms,
   output var scan_bridge_pkg::tap_state_t state,
   output scan_bridge_pkg::tap_state_t next_state
);
   import scan_bridge_pkg::*;

   // ==========================================================
   // next state
   always_comb
   begin
      next_state = state;
      if (!trst_n)
         next_state = TEST_LOGIC_RESET;
      else if (step)
      begin
         case (state)
            TEST_LOGIC_RESET:
               next_state = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: next_state = tms ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: next_state = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: next_state = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: next_state = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            default: next_state = TEST_LOGIC_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         state <= TEST_LOGIC_RESET;
      else
         state <= next_state;
   end

endmodule
`default_nettype wire

// ### rtl/user_scan_bridge.sv
// bridge from the test access port to user core logic
// What this block does
// - core sees an 8-bit copy of the current instruction register
// - codes 16 to 127 are user instructions the core may decode
// - the copy changes only on entering Update-IR, or returns to FF in Test-Logic-Reset
// - core reset output is low while in Test-Logic-Reset
// - after power-up core reset stays low until the controller leaves reset
// - user serial output reaches TDO only under a user instruction
// - shift, update and capture flags high exactly in their DR states
// - core serial input and scan clock are TDI and TCK passed straight
// - controller has sixteen states driven by TMS at TCK rise and forced to Test-Logic-Reset by TRST
// - after reset state moves only on a TCK rising edge or while TRST is low
// - power-up or TRST puts the controller in Test-Logic-Reset
// - five or more TCK cycles with TMS high reach Test-Logic-Reset
// - TDI shifts into data register in Shift-DR, instruction in Shift-IR
// - instruction register works in IR states, data register in DR states
// - codes 00, 01 and FF are reserved, outside the user range
`timescale 1ns/1ps
`default_nettype none
module user_scan_bridge #(
   parameter int FIFO_DEPTH_P = scan_bridge_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo,
   output logic tdo_oe,
   output logic [7:0] instr_reg_mirror,
   output logic user_instr,
   output logic tap_reset_n_out,
   output logic user_serial_in,
   output logic user_scan_clock,
   input wire logic user_serial_out,
   output logic shift_dr_flag,
   output logic capture_dr_flag,
   output logic update_dr_flag,
   output logic word_valid,
   input wire logic word_ready,
   output wire scan_bridge_pkg::scan_word_t word_data,
   output logic word_overrun
);
   import scan_bridge_pkg::*;

   logic [SYN_WIDTH-1:0] sync1;
   logic [SYN_WIDTH-1:0] sync2;
   logic tck_d;
   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;
   logic trst_n_s;
   logic user_serial_out_s;
   tap_state_t state;
   tap_state_t next_state;
   logic [IR_WIDTH-1:0] ir_shift;
   logic bypass_bit;
   logic tdo_next;
   logic [WORD_BITS-1:0] byte_shift;
   logic [WORD_BITS-1:0] next_byte;
   logic [2:0] bit_cnt;
   logic byte_done;
   scan_word_t pend;
   logic pend_valid;
   logic pend_ready;
   logic [2:0] tms_hi_cnt;

   // ==========================================================
   // elaboration check
   generate
      if (TCK_HALF_CYCLES < 3 || FIFO_DEPTH_P < 2)
      begin : g_bad_cfg
         $error("user_scan_bridge: tck too fast or fifo too small");
      end
   endgenerate

   // ==========================================================
   // pin sampling, two stages before any use except the core pass-throughs
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sync1 <= SYN_RESET;
         sync2 <= SYN_RESET;
         tck_d <= 1'b0;
      end
      else
      begin
         sync1 <= {user_serial_out, trst_n, tdi, tms, tck};
         sync2 <= sync1;
         tck_d <= sync2[SYN_TCK];
      end
   end

   assign tms_s = sync2[SYN_TMS];
   assign tdi_s = sync2[SYN_TDI];
   assign trst_n_s = sync2[SYN_TRST];
   assign user_serial_out_s = sync2[SYN_USER_SERIAL_OUT];
   assign tck_rise = sync2[SYN_TCK] & ~tck_d;
   assign tck_fall = ~sync2[SYN_TCK] & tck_d;

   // ==========================================================
   // straight pass-throughs to the core
   assign user_serial_in = tdi;
   assign user_scan_clock = tck;

   // ==========================================================
   // controller
   tap_state_machine u_tap (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .trst_n(trst_n_s),
      .step(tck_rise),
      .tms(tms_s),
      .state(state),
      .next_state(next_state)
   );

   // ==========================================================
   // state flags and core reset, aligned with the state register
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         tap_reset_n_out <= 1'b0;
         shift_dr_flag <= 1'b0;
         capture_dr_flag <= 1'b0;
         update_dr_flag <= 1'b0;
      end
      else
      begin
         tap_reset_n_out <= (next_state != TEST_LOGIC_RESET);
         shift_dr_flag <= (next_state == SHIFT_DR);
         capture_dr_flag <= (next_state == CAPTURE_DR);
         update_dr_flag <= (next_state == UPDATE_DR);
      end
   end

   // ==========================================================
   // instruction shift register, IR states only
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         ir_shift <= IR_RESET;
      else if (tck_rise)
      begin
         case (state)
            CAPTURE_IR: ir_shift <= IR_CAPTURE;
            SHIFT_IR: ir_shift <= {tdi_s, ir_shift[IR_WIDTH-1:1]};
            default: ir_shift <= ir_shift;
         endcase
      end
   end

   // ==========================================================
   // instruction copy for the core
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         instr_reg_mirror <= IR_RESET;
      else if (next_state == TEST_LOGIC_RESET)
         instr_reg_mirror <= IR_RESET;
      else if (tck_rise && next_state == UPDATE_IR)
         instr_reg_mirror <= ir_shift;
   end

   // reserved codes 00, 01, ff fall outside this window
   assign user_instr = (instr_reg_mirror >= USER_FIRST) &&
                       (instr_reg_mirror <= USER_LAST);

   // ==========================================================
   // bypass bit, serves every non-user instruction
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         bypass_bit <= 1'b0;
      else if (tck_rise)
      begin
         case (state)
            CAPTURE_DR: bypass_bit <= 1'b0;
            SHIFT_DR: bypass_bit <= tdi_s;
            default: bypass_bit <= bypass_bit;
         endcase
      end
   end

   // ==========================================================
   // tdo multiplexer, updated on falling tck
   always_comb
   begin
      if (state == SHIFT_IR)
         tdo_next = ir_shift[0];
      else if (user_instr)
         tdo_next = user_serial_out_s;
      else
         tdo_next = bypass_bit;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo <= tdo_next;
         tdo_oe <= (state == SHIFT_IR) || (state == SHIFT_DR);
      end
   end

   // ==========================================================
   // user data stream: shifted bits packed into bytes
   assign next_byte = {tdi_s, byte_shift[WORD_BITS-1:1]};
   assign byte_done = tck_rise && state == SHIFT_DR && user_instr &&
                      bit_cnt == BIT_LAST;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         byte_shift <= '0;
         bit_cnt <= BIT_FIRST;
      end
      else if (tck_rise)
      begin
         if (state == CAPTURE_DR)
            bit_cnt <= BIT_FIRST;
         else if (state == SHIFT_DR && user_instr)
         begin
            byte_shift <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
         end
      end
   end

   // one staging word; a full fifo stalls it
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pend_valid <= 1'b0;
         pend <= '0;
      end
      else if (byte_done && (!pend_valid || pend_ready))
      begin
         pend_valid <= 1'b1;
         pend.instr <= instr_reg_mirror;
         pend.data <= next_byte;
      end
      else if (pend_ready)
         pend_valid <= 1'b0;
   end

   // byte lost while staging is stalled; set wins over clear
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         word_overrun <= 1'b0;
      else if (byte_done && pend_valid && !pend_ready)
         word_overrun <= 1'b1;
      else if (state == TEST_LOGIC_RESET)
         word_overrun <= 1'b0;
   end

   scan_fifo #(
      .WIDTH($bits(scan_word_t)),
      .DEPTH(FIFO_DEPTH_P)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(pend_valid),
      .in_ready(pend_ready),
      .in_data(pend),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_data)
   );

   // ==========================================================
   // checks
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         tms_hi_cnt <= 3'h0;
      else if (tck_rise)
      begin
         if (!tms_s)
            tms_hi_cnt <= 3'h0;
         else if (tms_hi_cnt != TMS_RESET_CYCLES)
            tms_hi_cnt <= tms_hi_cnt + 3'h1;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_capture_step;
      capture_dr_flag && tck_rise && !tms_s && trst_n_s;
   endsequence

   sequence s_in_shift;
      shift_dr_flag && !capture_dr_flag && !update_dr_flag;
   endsequence

   a_mirror_on_update: assert property (
      $changed(instr_reg_mirror) |->
         state inside {UPDATE_IR, TEST_LOGIC_RESET})
      else $error("instruction copy changed outside Update-IR");

   a_reset_out_tlr: assert property (
      (state == TEST_LOGIC_RESET) == !tap_reset_n_out)
      else $error("core reset does not follow Test-Logic-Reset");

   a_five_tms_reset: assert property (
      (tms_hi_cnt == TMS_RESET_CYCLES) |-> state == TEST_LOGIC_RESET)
      else $error("five tms-high cycles did not reach reset");

   a_trst_forces_reset: assert property (
      !trst_n_s |=> state == TEST_LOGIC_RESET && !tap_reset_n_out)
      else $error("trst did not force Test-Logic-Reset");

   a_state_on_edge: assert property (
      (!tck_rise && trst_n_s) |=> $stable(state))
      else $error("state moved without a tck rising edge");

   a_tdo_user_path: assert property (
      (tck_fall && state == SHIFT_DR && user_instr) |=>
         tdo == $past(user_serial_out_s) && tdo_oe)
      else $error("user serial output not routed to tdo");

   a_ir_shift_in: assert property (
      (tck_rise && state == SHIFT_IR) |=>
         ir_shift[IR_WIDTH-1] == $past(tdi_s))
      else $error("tdi not shifted into instruction register");

   a_ir_only_ir: assert property (
      $changed(ir_shift) |-> $past(state) inside {CAPTURE_IR, SHIFT_IR})
      else $error("instruction register moved outside IR states");

   a_capture_to_shift: assert property (
      s_capture_step |=> s_in_shift)
      else $error("Capture-DR with tms low did not raise shift flag");

   a_word_user_only: assert property (
      pend_valid |-> pend.instr >= USER_FIRST && pend.instr <= USER_LAST)
      else $error("stream word carries a non-user instruction");

endmodule
`default_nettype wire

// ### tb/jtag_host_model.sv
// test host model driving the scan pins of the bridge
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   output var logic trst_n,
   input wire logic tdo,
   input wire logic tdo_oe
);
   // ==========================================
   // idle: tck parked low, pulled-up lines high
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b1;
   end

   // ==========================================
   // one 400 ns tck period, tdo taken before the fall
   task automatic step(input logic tms_v, input logic tdi_v,
                       output logic tdo_v);
      #10;
      tms = tms_v;
      tdi = tdi_v;
      #100;
      tck = 1'b1;
      #200;
      // released tdo floats: show the opposite of its last level
      tdo_v = tdo_oe ? tdo : ~tdo;
      tck = 1'b0;
      tdi = 1'b1;
      #90;
   endtask

   // full pass Run-Test-Idle via Select-DR to Exit1-IR, caller finishes the update
   task automatic load_ir(input logic [7:0] code,
                          output logic [7:0] cap);
      logic d;
      step(1'b1, 1'b1, d);
      step(1'b1, 1'b1, d);
      step(1'b0, 1'b1, d);
      step(1'b0, 1'b1, d);
      for (int i = 0; i < 8; i++)
      begin
         step(i == 7, code[i], cap[i]);
      end
   endtask

   // five tck rises with tms high
   task automatic tms_reset();
      logic d;
      repeat (5) step(1'b1, 1'b1, d);
   endtask

   task automatic trst_pulse();
      #10;
      trst_n = 1'b0;
      #500;
      trst_n = 1'b1;
      #190;
   endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the user scan bridge
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import scan_bridge_pkg::*;
   typedef struct packed {
      logic [7:0] code;
      logic user;
      logic [7:0] tdo_exp;
   } ir_row_t;
   ir_row_t rows [8];
   logic clk_sys, rst_n, word_ready, user_serial_out;
   logic tck, tms, tdi, trst_n;
   logic tdo, tdo_oe, user_instr, tap_reset_n_out, word_valid, word_overrun;
   logic [7:0] instr_reg_mirror, prev, cap, out;
   logic user_serial_in, user_scan_clock, d;
   logic shift_dr_flag, capture_dr_flag, update_dr_flag;
   scan_word_t word_data;
   int mismatches = 0;
   int n_checks = 0;
   int k;

   user_scan_bridge #(.FIFO_DEPTH_P(4)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
      .instr_reg_mirror(instr_reg_mirror), .user_instr(user_instr),
      .tap_reset_n_out(tap_reset_n_out), .user_serial_in(user_serial_in),
      .user_scan_clock(user_scan_clock), .user_serial_out(user_serial_out),
      .shift_dr_flag(shift_dr_flag), .capture_dr_flag(capture_dr_flag),
      .update_dr_flag(update_dr_flag), .word_valid(word_valid),
      .word_ready(word_ready), .word_data(word_data),
      .word_overrun(word_overrun));

   jtag_host_model host (
      .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
      .tdo_oe(tdo_oe));

   // ==========================================
   // clock and shared tasks
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp,
                        input string what);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic flags(input logic [2:0] exp);
      check({shift_dr_flag, capture_dr_flag, update_dr_flag}, exp,
            "dr flags");
   endtask

   // one data scan from Run-Test-Idle back to Run-Test-Idle
   task automatic dr_scan(input logic [7:0] b, output logic [7:0] o);
      logic x;
      host.step(1'b1, 1'b1, x);
      host.step(1'b0, 1'b1, x);
      flags(3'b010);
      #1000;
      flags(3'b010);
      host.step(1'b0, 1'b1, x);
      flags(3'b100);
      for (int i = 0; i < 8; i++)
      begin
         host.step(i == 7, b[i], o[i]);
      end
      flags(3'b000);
      host.step(1'b1, 1'b1, x);
      flags(3'b001);
      host.step(1'b0, 1'b1, x);
      flags(3'b000);
   endtask

   // pass-through pins seen at every system clock
   always @(negedge clk_sys)
   begin
      check(user_serial_in, tdi, "serial in");
      check(user_scan_clock, tck, "scan clock");
   end

   // ==========================================
   // main sequence
   initial
   begin
      rows = '{'{8'h00, 1'b0, 8'hfe}, '{8'h01, 1'b0, 8'hfe},
               '{8'h0f, 1'b0, 8'hfe}, '{8'hff, 1'b0, 8'hfe},
               '{8'h10, 1'b1, 8'hff}, '{8'h7f, 1'b1, 8'hff},
               '{8'h80, 1'b0, 8'hfe}, '{8'h20, 1'b1, 8'hff}};
      rst_n = 1'b0;
      word_ready = 1'b0;
      user_serial_out = 1'b1;
      prev = 8'hff;
      repeat (12) @(posedge clk_sys);
      check(tap_reset_n_out, 1'b0, "reset out");
      check(instr_reg_mirror, 8'hff, "mirror at reset");
      flags(3'b000);
      rst_n <= 1'b1;
      word_ready <= 1'b1;
      repeat (20) @(posedge clk_sys);
      check(tap_reset_n_out, 1'b0, "reset out idle");
      host.step(1'b0, 1'b1, d);
      check(tap_reset_n_out, 1'b1, "reset out left");
      foreach (rows[i])
      begin
         host.load_ir(rows[i].code, cap);
         check(cap, IR_CAPTURE, "ir capture");
         check(instr_reg_mirror, prev, "mirror early");
         host.step(1'b1, 1'b1, d);
         check(instr_reg_mirror, rows[i].code, "mirror");
         check(user_instr, rows[i].user, "user range");
         host.step(1'b0, 1'b1, d);
         dr_scan(8'hff, out);
         check(out, rows[i].tdo_exp, "tdo select");
         check(instr_reg_mirror, rows[i].code, "mirror held");
         prev = rows[i].code;
      end
      // fill the stream while the core stalls
      @(posedge clk_sys) word_ready <= 1'b0;
      for (int j = 0; j < 6; j++)
      begin
         dr_scan(8'h30 + j[7:0], out);
      end
      check(word_overrun, 1'b1, "overrun");
      check(word_valid, 1'b1, "valid stalled");
      @(posedge clk_sys) word_ready <= 1'b1;
      k = 0;
      repeat (20)
      begin
         @(negedge clk_sys);
         if (word_valid === 1'b1)
         begin
            check(word_data, {8'h20, 8'h30 + k[7:0]}, "word");
            k++;
         end
      end
      check(k[15:0], 16'h0005, "word count");
      // five tms-high rises from Shift-DR
      host.step(1'b1, 1'b1, d);
      host.step(1'b0, 1'b1, d);
      host.step(1'b0, 1'b1, d);
      repeat (4) host.step(1'b1, 1'b1, d);
      check(tap_reset_n_out, 1'b1, "four rises");
      host.step(1'b1, 1'b1, d);
      check(tap_reset_n_out, 1'b0, "five rises");
      check(instr_reg_mirror, 8'hff, "mirror reset");
      check(word_overrun, 1'b0, "overrun cleared");
      // test reset pin in mid-run
      host.step(1'b0, 1'b1, d);
      host.load_ir(8'h40, cap);
      host.step(1'b1, 1'b1, d);
      host.step(1'b0, 1'b1, d);
      check(instr_reg_mirror, 8'h40, "mirror user");
      host.trst_pulse();
      check(tap_reset_n_out, 1'b0, "trst");
      check(instr_reg_mirror, 8'hff, "trst mirror");
      stop_test();
   end
endmodule
`default_nettype wire
